// >>> hw/srcc_pkg.sv
package srcc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [31:0] SRCC_CLOCK_CONTROL_ADDR     = 32'hffffffd0;
  localparam logic [31:0] SRCC_EXCEPTION_CONTROL_ADDR = 32'hffffffe0;
  localparam logic [31:0] SRCC_EXCEPTION_STATUS_ADDR  = 32'hffffffe4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SRCC_DIV_LSB      = 8;
  localparam int SRCC_SRC_LSB      = 5;
  localparam int SRCC_LEVEL_BIT    = 3;
  localparam int SRCC_SOFTWARE_RESET_FLAG_LSB    = 14;
  localparam int SRCC_PERIPH_OVR   = 2;
  localparam int SRCC_MEM_OVR      = 1;
  localparam int SRCC_ADDR_OVR     = 0;
  localparam int SRCC_FLAG_POWER   = 15;
  localparam int SRCC_FLAG_CLK     = 14;
  localparam int SRCC_FLAG_WDOG    = 13;
  localparam int SRCC_FLAG_MODE    = 12;
  localparam int SRCC_FLAG_ADDR    = 11;
  localparam int SRCC_FLAG_ACCESS  = 10;
  localparam int SRCC_FLAG_PERIPH  = 9;
  localparam int SRCC_FLAG_MAP     = 8;
  localparam int SRCC_FLAG_SW      = 7;

  // ****************************************************************
  // masks, reset values and counts
  // ****************************************************************
  localparam logic [15:0] SRCC_CLOCK_CONTROL_MASK = 16'h0368;
  localparam logic [15:0] SRCC_EXC_CTRL_MASK      = 16'h0007;
  localparam logic [15:0] SRCC_STATUS_MASK        = 16'hff80;
  localparam logic [1:0]  SRCC_SOFTWARE_RESET_FLAG_IDLE         = 2'h1;
  localparam logic [15:0] SRCC_CLOCK_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] SRCC_EXC_CTRL_RST       = 16'h0000;
  localparam logic [15:0] SRCC_STATUS_RST         = 16'h0000;
  localparam logic [1:0]  SRCC_CLK_WAIT           = 2'h1;
  localparam logic [2:0]  SRCC_SOFTWARE_RESET_FLAG_PULSE        = 3'h4;
  localparam logic [2:0]  SRCC_HTRANS_NONSEQ      = 3'h2;

  typedef enum logic [1:0] {
    SRCC_SRC_LEVEL,
    SRCC_SRC_INTERFACE_CLOCK,
    SRCC_SRC_MCLK,
    SRCC_SRC_SYSTEM_CLOCK
  } srcc_src_t;

  // one pending bus transfer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        priv;
    logic [31:0] addr;
    logic [3:0]  lanes;
  } srcc_xfer_t;

  // violation and reset event inputs
  typedef struct packed {
    logic clock_fail;
    logic watchdog;
    logic bad_mode;
    logic bad_address;
    logic bad_access;
    logic periph_violation;
    logic map_overlap;
  } srcc_events_t;
endpackage : srcc_pkg

// >>> hw/srcc_top.sv
// Chosen here: register access over AHB-Lite.
module srcc_top
  import srcc_pkg::*;
(
  // clock and power-on reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // event inputs, asynchronous to clk
  input  wire srcc_events_t events_in,
  input  wire logic        test_reset,
  // clock sources for the output pin
  input  wire logic        interface_clock,
  input  wire logic        processor_clock,
  // outputs
  output logic      [1:0]  mclk_div_sel,
  output logic             clock_out_pin,
  output logic             global_reset,
  output logic             violation_reset
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    srcc_xfer_t   xfer;
    logic [1:0]   wait_cnt;
    logic [15:0]  clock_control;
    logic [15:0]  exc_ctrl;
    logic [15:0]  status;
    logic         por_seen;
    logic [2:0]   software_reset_flag_cnt;
    srcc_events_t ev_meta;
    srcc_events_t ev_sync;
    logic [1:0]   trst_sync;
    logic [1:0]   interface_clock_sync;
    logic [1:0]   mclk_sync;
    logic         sys_div;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         clk_out;
    logic         gbl_rst;
    logic         vio_rst;
  } srcc_state_t;

  srcc_state_t st;
  srcc_state_t next_st;

  // byte lanes of a write from size and address
  function automatic logic [3:0] srcc_lanes(input logic [2:0] sz, input logic [1:0] a);
    logic [3:0] l;
    l = 4'h0;
    unique case (sz)
      3'h0:    l = 4'h1 << a;
      3'h1:    l = a[1] ? 4'hc : 4'h3;
      default: l = 4'hf;
    endcase
    return l;
  endfunction : srcc_lanes

  // register read mux; reserved bits read zero, reset field reads idle
  function automatic logic [15:0] srcc_read(input logic [31:0] a, input logic [15:0] cc,
                                            input logic [15:0] ec, input logic [15:0] sr);
    logic [15:0] r;
    r = 16'h0000;
    unique case (a)
      SRCC_CLOCK_CONTROL_ADDR:     r = cc & SRCC_CLOCK_CONTROL_MASK;
      SRCC_EXCEPTION_CONTROL_ADDR: r = {SRCC_SOFTWARE_RESET_FLAG_IDLE, 14'h0000} |
                                       (ec & SRCC_EXC_CTRL_MASK);
      SRCC_EXCEPTION_STATUS_ADDR:  r = sr & SRCC_STATUS_MASK;
      default:                     r = 16'h0000;
    endcase
    return r;
  endfunction : srcc_read

  // expand low two lanes into a 16-bit bit mask
  function automatic logic [15:0] srcc_bitmask(input logic [3:0] l);
    return {{8{l[1]}}, {8{l[0]}}};
  endfunction : srcc_bitmask

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [15:0]  wd;
    logic [15:0]  bm;
    logic         take;
    logic         fin;
    logic [15:0]  rd;
    logic         ovr_on;
    srcc_events_t e;
    logic [15:0]  set;
    logic         swreq;
    wd      = 16'h0000;
    bm      = 16'h0000;
    rd      = 16'h0000;
    set     = 16'h0000;
    swreq   = 1'b0;
    next_st = st;
    // pins into two-stage synchronisers
    next_st.ev_meta   = events_in;
    next_st.ev_sync   = st.ev_meta;
    next_st.trst_sync = {st.trst_sync[0], test_reset};
    next_st.interface_clock_sync = {st.interface_clock_sync[0], interface_clock};
    next_st.mclk_sync = {st.mclk_sync[0], processor_clock};
    next_st.sys_div   = ~st.sys_div;
    e                 = st.ev_sync;
    ovr_on            = st.trst_sync[1];

    // address phase capture
    take = hsel && hready && htrans[1];
    fin  = st.xfer.valid && (st.wait_cnt == 2'h0);
    if (take) begin
      next_st.xfer.valid = 1'b1;
      next_st.xfer.write = hwrite;
      next_st.xfer.priv  = hprot[1];
      next_st.xfer.addr  = {haddr[31:2], 2'b00};
      next_st.xfer.lanes = srcc_lanes(hsize, haddr[1:0]);
      // clock control holds the data phase one extra cycle
      next_st.wait_cnt   = ({haddr[31:2], 2'b00} == SRCC_CLOCK_CONTROL_ADDR) ?
                           SRCC_CLK_WAIT : 2'h0;
      next_st.hreadyout  = ({haddr[31:2], 2'b00} != SRCC_CLOCK_CONTROL_ADDR);
    end else if (st.xfer.valid && !fin) begin
      next_st.wait_cnt  = st.wait_cnt - 2'h1;
      next_st.hreadyout = (st.wait_cnt == 2'h1);
    end else if (fin) begin
      next_st.xfer.valid = 1'b0;
      next_st.hreadyout  = 1'b1;
    end

    // write in the last data cycle, byte lanes honoured
    if (fin && st.xfer.write) begin
      wd = hwdata[15:0];
      bm = srcc_bitmask(st.xfer.lanes);
      unique case (st.xfer.addr)
        SRCC_CLOCK_CONTROL_ADDR: begin
          next_st.clock_control = ((st.clock_control & ~bm) | (wd & bm)) &
                                  SRCC_CLOCK_CONTROL_MASK;
        end
        SRCC_EXCEPTION_CONTROL_ADDR: begin
          // unprivileged writes are dropped silently, bus still says okay
          if (st.xfer.priv) begin
            next_st.exc_ctrl = ((st.exc_ctrl & ~bm) | (wd & bm)) & SRCC_EXC_CTRL_MASK;
            if (bm[15] && wd[15:14] != SRCC_SOFTWARE_RESET_FLAG_IDLE) begin
              swreq = 1'b1;
            end
          end
        end
        SRCC_EXCEPTION_STATUS_ADDR: begin
          // zero in an enabled lane clears, one keeps
          next_st.status = st.status & ~(bm & ~wd) & SRCC_STATUS_MASK;
        end
        default: ;
      endcase
    end

    // event flags; a set wins over a clear in the same cycle
    set[SRCC_FLAG_POWER]  = !st.por_seen;
    set[SRCC_FLAG_CLK]    = e.clock_fail;
    set[SRCC_FLAG_WDOG]   = e.watchdog;
    set[SRCC_FLAG_MODE]   = e.bad_mode;
    set[SRCC_FLAG_ADDR]   = e.bad_address;
    set[SRCC_FLAG_ACCESS] = e.bad_access;
    set[SRCC_FLAG_PERIPH] = e.periph_violation;
    set[SRCC_FLAG_MAP]    = e.map_overlap;
    set[SRCC_FLAG_SW]     = swreq;
    next_st.status   = next_st.status | set;
    next_st.por_seen = 1'b1;

    // software reset pulse; flags live outside its reach
    if (swreq) begin
      next_st.software_reset_flag_cnt = SRCC_SOFTWARE_RESET_FLAG_PULSE;
    end else if (st.software_reset_flag_cnt != 3'h0) begin
      next_st.software_reset_flag_cnt = st.software_reset_flag_cnt - 3'h1;
    end
    next_st.gbl_rst = (next_st.software_reset_flag_cnt != 3'h0) || e.watchdog || e.clock_fail;

    // violation response with test-only overrides
    next_st.vio_rst = (e.periph_violation &&
                       !(ovr_on && st.exc_ctrl[SRCC_PERIPH_OVR])) ||
                      (e.bad_access &&
                       !(ovr_on && st.exc_ctrl[SRCC_MEM_OVR])) ||
                      (e.bad_address &&
                       !(ovr_on && st.exc_ctrl[SRCC_ADDR_OVR])) ||
                      e.map_overlap || e.bad_mode;

    // read data registered at the address phase so it stands through the data phase;
    // taken from the stored-next values so a write just ahead is already visible
    rd = srcc_read({haddr[31:2], 2'b00}, next_st.clock_control, next_st.exc_ctrl,
                   next_st.status);
    if (take && !hwrite) begin
      next_st.hrdata = {16'h0000, rd};
    end

    // clock output mux; level source is static
    unique case (srcc_src_t'(st.clock_control[SRCC_SRC_LSB +: 2]))
      SRCC_SRC_LEVEL:  next_st.clk_out = st.clock_control[SRCC_LEVEL_BIT];
      SRCC_SRC_INTERFACE_CLOCK:   next_st.clk_out = st.interface_clock_sync[1];
      SRCC_SRC_MCLK:   next_st.clk_out = st.mclk_sync[1];
      SRCC_SRC_SYSTEM_CLOCK: next_st.clk_out = st.sys_div;
    endcase
  end

  // ****************************************************************
  // registers; only power-on reset clears the flags
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st               <= '0;
      st.hreadyout     <= 1'b1;
      st.clock_control <= SRCC_CLOCK_CONTROL_RST;
      st.exc_ctrl      <= SRCC_EXC_CTRL_RST;
      st.status        <= SRCC_STATUS_RST;
      st.gbl_rst       <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs straight from flops, hresp tied to okay
  // ****************************************************************
  assign hrdata          = st.hrdata;
  assign hreadyout       = st.hreadyout;
  assign hresp           = 1'b0;
  assign mclk_div_sel    = st.clock_control[SRCC_DIV_LSB +: 2];
  assign clock_out_pin   = st.clk_out;
  assign global_reset    = st.gbl_rst;
  assign violation_reset = st.vio_rst;

endmodule : srcc_top

// >>> dv/srcc_asserts.sv
module srcc_asserts
  import srcc_pkg::*;
(
  // clock, reset and bus
  input wire logic         clk,
  input wire logic         resetn,
  input wire logic         hsel,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic [3:0]   hprot,
  input wire logic [31:0]  hwdata,
  input wire logic [31:0]  hrdata,
  input wire logic         hreadyout,
  input wire logic         hresp,
  // events and resets
  input wire srcc_events_t events_in,
  input wire logic         global_reset,
  input wire logic         violation_reset
);
  // ******************************
  // bus and reset checks
  // ******************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic viol;
  // only violation causes may raise violation_reset, never watchdog or clock fail
  assign viol = events_in.bad_address | events_in.bad_access | events_in.periph_violation |
                events_in.map_overlap | events_in.bad_mode;
  sequence s_take(logic [31:0] a, logic w);
    hsel && hreadyout && htrans[1] && haddr == a && hwrite == w;
  endsequence
  sequence s_sw_write;
    hsel && hreadyout && htrans[1] && hwrite && hprot[1] && haddr == SRCC_EXCEPTION_CONTROL_ADDR
      ##1 hwdata[15:14] != 2'h1;
  endsequence
  property p_upper; hrdata[31:16] == 16'h0; endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_clk_wait;
    s_take(SRCC_CLOCK_CONTROL_ADDR, 1'b0) |=> !hreadyout ##1 hreadyout
      && (hrdata[15:0] & ~SRCC_CLOCK_CONTROL_MASK) == 16'h0;
  endproperty
  property p_exc_read; s_take(SRCC_EXCEPTION_CONTROL_ADDR, 1'b0) |=> hrdata[15:3] == 13'h0800;
  endproperty
  property p_stat_read;
    s_take(SRCC_EXCEPTION_STATUS_ADDR, 1'b0) |=> hreadyout && hrdata[6:0] == 7'h0;
  endproperty
  property p_sw_reset; s_sw_write |-> ##[1:3] global_reset [*4]; endproperty
  property p_por_hold; $rose(resetn) |-> global_reset ##1 !global_reset; endproperty
  property p_violation;
    $rose(violation_reset) |-> $past(viol, 2) || $past(viol, 3) || $past(viol, 4) || $past(viol, 5);
  endproperty
  a_upper: assert property (p_upper) else $error("upper read data set");
  a_okay: assert property (p_okay) else $error("error response");
  a_clk_wait: assert property (p_clk_wait) else $error("clock control timing");
  a_exc_read: assert property (p_exc_read) else $error("control readback");
  a_stat_read: assert property (p_stat_read) else $error("status readback");
  a_sw_reset: assert property (p_sw_reset) else $error("software reset pulse");
  a_por_hold: assert property (p_por_hold) else $error("power-on hold");
  a_violation: assert property (p_violation) else $error("stray violation");
endmodule : srcc_asserts

bind srcc_top srcc_asserts u_chk (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hprot,
  .hwdata, .hrdata, .hreadyout, .hresp, .events_in, .global_reset, .violation_reset);

// >>> dv/srcc_cpu_model.sv
module srcc_cpu_model (
  // answer from the slave
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // request to the slave
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [3:0]       hprot,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {hsel, haddr, htrans, hwrite, hsize, hprot, hwdata} = '0;
  // a stuck slave ends the run instead of hanging it
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 64) begin
        testbench.bad_count++;
        testbench.give_verdict();
      end
    end while (hready !== 1'b1);
  endtask : wait_ready
  // single word transfer; released lines show the inverse so stale values never match
  task automatic xfer(input logic w, input logic p, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    hprot  <= {2'h0, p, 1'b1};
    wait_ready();
    htrans <= 2'h0;
    haddr  <= ~a;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    hwdata <= ~wd;
  endtask : xfer
endmodule : srcc_cpu_model

// >>> dv/srcc_tb.sv
module testbench
  import srcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, resetn, test_reset, ic, pc, hsel, hwrite, hreadyout, hresp, co, gr, vr, vr_q;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans, div;
  logic [2:0]   hsize;
  logic [3:0]   hprot;
  srcc_events_t ev;
  int           bad_count = 0, tests_run = 0, vr_rises = 0, gr_cycles = 0;
  // ******************************
  // clocks, design and bus master
  // ******************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // output-pin sources never land on a rising clk edge
  initial begin
    ic = 1'b0;
    forever #21 ic = ~ic;
  end
  initial begin
    pc = 1'b0;
    forever #11 pc = ~pc;
  end
  // count reset cycles and violation rises
  always @(posedge clk) begin
    if (vr === 1'b1 && vr_q !== 1'b1) vr_rises++;
    if (gr === 1'b1) gr_cycles++;
    vr_q = vr;
  end
  srcc_top DUT (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hprot, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .events_in(ev), .test_reset,
    .interface_clock(ic), .processor_clock(pc), .mclk_div_sel(div), .clock_out_pin(co),
    .global_reset(gr), .violation_reset(vr));
  srcc_cpu_model cpu (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hprot, .hwdata);
  // ******************************
  // helpers
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [31:0] a, input logic [15:0] v, input logic p);
    logic [31:0] x;
    cpu.xfer(1'b1, p, a, {16'h0, v}, x);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    logic [31:0] x;
    cpu.xfer(1'b0, 1'b1, a, 32'h0, x);
    check(x, {16'h0, e});
  endtask : rd
  task automatic pulse(input int i);
    ev <= srcc_events_t'(7'h1 << i);
    repeat (3) @(posedge clk);
    ev <= '0;
    repeat (10) @(posedge clk);
  endtask : pulse
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  // ******************************
  // scenarios
  // ******************************
  task automatic t_clock;
    int n;
    int e[4] = '{0, 15, 29, 64};
    logic p;
    rd(SRCC_EXCEPTION_STATUS_ADDR, 16'h8000);
    rd(SRCC_EXCEPTION_CONTROL_ADDR, 16'h4000);
    for (int s = 0; s < 4; s++) begin
      rd(SRCC_CLOCK_CONTROL_ADDR, 16'(s << 8) & 16'h0300 | 16'(s << 5) & 16'h0060);
      wr(SRCC_CLOCK_CONTROL_ADDR, 16'hfc97 | 16'((s + 1) % 4 << 8) | 16'((s + 1) % 4 << 5), 1'b0);
      @(posedge clk);
      check({30'h0, div}, 32'((s + 1) % 4));
      repeat (8) @(posedge clk);
      n = 0;
      p = co;
      repeat (64) begin
        @(posedge clk);
        if (co !== p) n++;
        p = co;
      end
      check({31'h0, n >= e[(s + 1) % 4] - 1 && n <= e[(s + 1) % 4] + 1}, 32'h1);
    end
    for (int v = 1; v >= 0; v--) begin
      wr(SRCC_CLOCK_CONTROL_ADDR, 16'(v << 3), 1'b1);
      repeat (4) @(posedge clk);
      check({31'h0, co}, 32'(v));
    end
    $display("clock control done");
  endtask : t_clock
  task automatic t_flags;
    logic [15:0] e;
    int r;
    e = 16'h8000;
    for (int i = 0; i < 7; i++) begin
      r = vr_rises;
      pulse(i);
      e[8 + i] = 1'b1;
      rd(SRCC_EXCEPTION_STATUS_ADDR, e);
      if (i >= 1 && i <= 3) check(32'(vr_rises - r), 32'h1);
    end
    wr(SRCC_EXCEPTION_STATUS_ADDR, 16'hbfff, 1'b0);
    rd(SRCC_EXCEPTION_STATUS_ADDR, 16'hbf00);
    $display("status flags done");
  endtask : t_flags
  task automatic t_override;
    int r;
    test_reset <= 1'b1;
    wr(SRCC_EXCEPTION_CONTROL_ADDR, 16'h7fff, 1'b0);
    rd(SRCC_EXCEPTION_CONTROL_ADDR, 16'h4000);
    wr(SRCC_EXCEPTION_CONTROL_ADDR, 16'h7fff, 1'b1);
    rd(SRCC_EXCEPTION_CONTROL_ADDR, 16'h4007);
    for (int i = 1; i < 4; i++) begin
      r = vr_rises;
      pulse(i);
      check(32'(vr_rises - r), 32'h0);
    end
    test_reset <= 1'b0;
    repeat (4) @(posedge clk);
    r = vr_rises;
    pulse(3);
    check(32'(vr_rises - r), 32'h1);
    $display("overrides done");
  endtask : t_override
  task automatic t_swreset;
    logic [15:0] code[3] = '{16'h0000, 16'h8000, 16'hc000};
    int g;
    wr(SRCC_EXCEPTION_STATUS_ADDR, 16'h0000, 1'b0);
    g = gr_cycles;
    wr(SRCC_EXCEPTION_CONTROL_ADDR, 16'h0000, 1'b0);
    wr(SRCC_EXCEPTION_CONTROL_ADDR, 16'h4000, 1'b1);
    repeat (8) @(posedge clk);
    check(32'(gr_cycles - g), 32'h0);
    rd(SRCC_EXCEPTION_STATUS_ADDR, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      g = gr_cycles;
      wr(SRCC_EXCEPTION_CONTROL_ADDR, code[k], 1'b1);
      repeat (10) @(posedge clk);
      check(32'(gr_cycles - g), 32'h4);
      rd(SRCC_EXCEPTION_STATUS_ADDR, 16'h0080);
    end
    pulse(6);
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    check({31'h0, gr}, 32'h1);
    resetn <= 1'b1;
    @(posedge clk);
    rd(SRCC_EXCEPTION_STATUS_ADDR, 16'h8000);
    $display("software and power-on reset done");
  endtask : t_swreset
  initial begin
    resetn = 1'b0;
    test_reset = 1'b0;
    ev = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_clock();
    t_flags();
    t_override();
    t_swreset();
    give_verdict();
  end
endmodule : testbench
